// ---- rtl/rcpd_dimmer.sv ----
// How it works
// - Every channel has its own 8-bit colour level.
// - Each three consecutive channels share one module intensity level.
// - Intensity has 256 steps per module.
// - Intensity resets to all ones, meaning colour levels pass unscaled.
// - One global bit selects log or linear intensity mapping.
// - Channel duty is colour level times mapped intensity.
// - 12-bit duty from 9-bit PWM plus 3 dither bits.
// - Dithering lengthens the pulse by one step in duty[2:0] of every eight periods.
// - Dither on after reset; cleared gives plain 9-bit PWM.
// - PWM period runs near 24 kHz from the internal clock.
// - Channels 0,3,6,9 have a fixed rising edge at period start.
// - Channels 1,4,7,10 are centred on the period midpoint.
// - Channels 2,5,8,11 have a fixed falling edge at period end.
// - Power-save entered after all channels off for the deglitch time.
// - Host interface reset within 3 us of enable falling.
// - Power-save keeps settings and leaves on any addressed command.
// - Clearing core active switches all sink outputs off.
`timescale 1ns/100ps
`include "rcpd_cfg.svh"

module rcpd_dimmer #(
  parameter int SLEEP_CYCLES = `RCPD_SLEEP_DEGLITCH_CYCLES
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Settings.
  input wire logic [`RCPD_CHANNELS*8-1:0] channel_colour_level,
  input wire logic [`RCPD_MODULES*8-1:0] module_intensity_level,
  input wire rcpd_pkg::rcpd_ctrl_type ctrl,
  // Host interface events, from the host bus logic on this clock.
  input wire logic host_cmd_seen,
  // Enable pin, asynchronous.
  input wire logic chip_enable_pin,
  // Outputs.
  output logic [`RCPD_CHANNELS-1:0] sink_output,
  output logic power_save,
  output logic host_if_reset
);

  //////////////////////////////////////////////////////////////////////////
  // Enable pin synchroniser and host interface reset.

  logic en_meta;
  logic en_sync;
  logic en_prev;
  logic next_host_if_reset;

  // A falling enable resets the host side two to three cycles later,
  // far inside the 3 us allowed.
  always_comb
  begin
    next_host_if_reset = en_prev && !en_sync;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      en_meta <= 1'b0;
      en_sync <= 1'b0;
      en_prev <= 1'b0;
      host_if_reset <= 1'b0;
    end
    else
    begin
      en_meta <= chip_enable_pin;
      en_sync <= en_meta;
      en_prev <= en_sync;
      host_if_reset <= next_host_if_reset;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Step divider and period counter.

  localparam logic [7:0] STEP_LAST = 8'(`RCPD_STEP_CYCLES - 1);

  logic [7:0] div_count;
  logic [7:0] next_div_count;
  logic [8:0] period_count;
  logic [8:0] next_period_count;
  logic [2:0] dither_phase;
  logic [2:0] next_dither_phase;
  logic step_en;

  always_comb
  begin
    step_en = (div_count == STEP_LAST);
    next_div_count = step_en ? 8'h00 : div_count + 8'h01;
    next_period_count = period_count;
    next_dither_phase = dither_phase;
    if (step_en)
    begin
      next_period_count = period_count + 9'h001;
      if (period_count == `RCPD_PERIOD_LAST)
      begin
        next_dither_phase = dither_phase + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      div_count <= 8'h00;
      period_count <= 9'h000;
      dither_phase <= 3'h0;
    end
    else
    begin
      div_count <= next_div_count;
      period_count <= next_period_count;
      dither_phase <= next_dither_phase;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Intensity mapping and duty product.

  // Log curve: each 32-level segment doubles the factor and is linear
  // inside, giving an 8-bit factor. Exact curve shape is not critical to
  // colour balance, so a shift beats a table here.
  function automatic logic [7:0] log_map(input logic [7:0] lvl);
    logic [2:0] seg;
    logic [4:0] frac;
    logic [13:0] base;
    seg = lvl[7:5];
    frac = lvl[4:0];
    base = 14'({1'b1, frac}) << seg;
    log_map = (lvl == 8'h00) ? 8'h00 : base[12:5];
    if (lvl == 8'hFF)
    begin
      log_map = 8'hFF;
    end
  endfunction

  logic [11:0] duty [`RCPD_CHANNELS];
  logic any_on;

  always_comb
  begin
    logic [7:0] factor;
    logic [15:0] product;
    factor = 8'h00;
    product = 16'h0000;
    any_on = 1'b0;
    for (int ch = 0; ch < `RCPD_CHANNELS; ch++)
    begin
      factor = module_intensity_level[(ch/3)*8 +: 8];
      if (ctrl.log_scale_en)
      begin
        factor = log_map(factor);
      end
      // Full intensity passes the colour level through unscaled.
      product = channel_colour_level[ch*8 +: 8] * factor;
      if (factor == `RCPD_INTENSITY_RESET)
      begin
        product = {channel_colour_level[ch*8 +: 8], 8'h00};
      end
      duty[ch] = product[15:4];
      any_on = any_on | (duty[ch] != 12'h000);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Channel generators.

  logic [`RCPD_CHANNELS-1:0] chan_out;

  for (genvar g = 0; g < `RCPD_CHANNELS; g++)
  begin : g_chan
    localparam rcpd_pkg::rcpd_phase_type PH =
      rcpd_pkg::rcpd_phase_type'(g % 3);
    rcpd_channel #(
      .PHASE(PH)
    ) u_chan (
      .core_clk(core_clk),
      .reset(reset),
      .step_en(step_en),
      .period_count(period_count),
      .dither_phase(dither_phase),
      .duty(duty[g]),
      .dither_en(ctrl.dither_en),
      .core_active(ctrl.core_active && !power_save),
      .sink_output(chan_out[g])
    );
  end

  always_comb
  begin
    sink_output = chan_out;
  end

  //////////////////////////////////////////////////////////////////////////
  // Power-save deglitch timer.

  logic [23:0] idle_count;
  logic [23:0] next_idle_count;
  logic next_power_save;
  logic any_on_held;
  logic next_any_on_held;

  always_comb
  begin
    next_idle_count = idle_count;
    next_power_save = power_save;
    next_any_on_held = any_on_held;
    // Channels take new duty only at a period end, so this held copy keeps
    // the timer from starting while old pulses are still running.
    if (step_en && period_count == `RCPD_PERIOD_LAST)
    begin
      next_any_on_held = any_on;
    end
    if (!ctrl.core_active || !ctrl.autosleep_en || any_on || any_on_held)
    begin
      next_idle_count = 24'h000000;
      next_power_save = 1'b0;
    end
    else if (idle_count != 24'(SLEEP_CYCLES))
    begin
      next_idle_count = idle_count + 24'h000001;
    end
    else
    begin
      next_power_save = 1'b1;
    end
    // Settings are untouched; a command only wakes the core.
    if (host_cmd_seen)
    begin
      next_power_save = 1'b0;
      next_idle_count = 24'h000000;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      idle_count <= 24'h000000;
      power_save <= 1'b0;
      any_on_held <= 1'b0;
    end
    else
    begin
      idle_count <= next_idle_count;
      power_save <= next_power_save;
      any_on_held <= next_any_on_held;
    end
  end

endmodule

// ---- rtl/rcpd_cfg.svh ----
`ifndef RCPD_CFG_SVH
`define RCPD_CFG_SVH

// Core clock period in ns (25 MHz).
`define RCPD_CLK_PERIOD_NS 40
// Nominal PWM period rate in kHz.
`define RCPD_PWM_FREQ_KHZ 29
// Core cycles per PWM step, rounded to nearest: 512 steps per period.
// At 25 MHz this is two cycles, a period near 24 kHz; one cycle would
// overshoot to near 49 kHz, so two is the closest the clock allows.
`define RCPD_STEP_CYCLES \
  ((2000000 / (`RCPD_PWM_FREQ_KHZ * 512 * `RCPD_CLK_PERIOD_NS) + 1) / 2)
// Nominal sleep deglitch time in ms and its cycle count.
`define RCPD_SLEEP_DEGLITCH_MS 30
`define RCPD_SLEEP_DEGLITCH_CYCLES \
  (`RCPD_SLEEP_DEGLITCH_MS * 1000000 / `RCPD_CLK_PERIOD_NS)
// Reset value of the intensity level.
`define RCPD_INTENSITY_RESET 8'hFF
// Number of channels and modules.
`define RCPD_CHANNELS 12
`define RCPD_MODULES 4
// Last value of the 9-bit period counter.
`define RCPD_PERIOD_LAST 9'h1FF

`endif

// ---- rtl/rcpd_pkg.sv ----
package rcpd_pkg;

  typedef enum logic [1:0]
  {
    RCPD_PH_LEAD = 2'b00,
    RCPD_PH_CENTRE = 2'b01,
    RCPD_PH_TRAIL = 2'b10
  } rcpd_phase_type;

  typedef struct packed
  {
    logic core_active;
    logic log_scale_en;
    logic dither_en;
    logic autosleep_en;
  } rcpd_ctrl_type;

endpackage

// ---- rtl/rcpd_channel.sv ----
`timescale 1ns/100ps
`include "rcpd_cfg.svh"

module rcpd_channel #(
  parameter rcpd_pkg::rcpd_phase_type PHASE = rcpd_pkg::RCPD_PH_LEAD
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Timing.
  input wire logic step_en,
  input wire logic [8:0] period_count,
  input wire logic [2:0] dither_phase,
  // Duty.
  input wire logic [11:0] duty,
  input wire logic dither_en,
  input wire logic core_active,
  // Output.
  output logic sink_output
);

  logic [11:0] duty_held;
  logic [11:0] next_duty_held;
  logic next_sink_output;
  logic [9:0] width;
  logic [9:0] lo;
  logic [9:0] hi;
  logic extend;

  always_comb
  begin
    next_duty_held = duty_held;
    // A new duty is taken only as a period wraps, so no pulse is cut.
    if (step_en && period_count == `RCPD_PERIOD_LAST)
    begin
      next_duty_held = duty;
    end
    // One extra step in duty_held[2:0] of every eight periods.
    extend = dither_en && (dither_phase < duty_held[2:0]);
    width = {1'b0, duty_held[11:3]} + {9'h000, extend};
    lo = 10'h000;
    hi = width;
    unique case (PHASE)
      rcpd_pkg::RCPD_PH_LEAD:
      begin
        lo = 10'h000;
        hi = width;
      end
      rcpd_pkg::RCPD_PH_CENTRE:
      begin
        lo = 10'h100 - {1'b0, width[9:1]};
        hi = lo + width;
      end
      rcpd_pkg::RCPD_PH_TRAIL:
      begin
        lo = 10'h200 - width;
        hi = 10'h200;
      end
    endcase
    next_sink_output = core_active
      && ({1'b0, period_count} >= lo) && ({1'b0, period_count} < hi);
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      duty_held <= 12'h000;
      sink_output <= 1'b0;
    end
    else
    begin
      duty_held <= next_duty_held;
      sink_output <= next_sink_output;
    end
  end

endmodule

// ---- dv/rcpd_dimmer_asserts.sv ----
`timescale 1ns/100ps
`include "rcpd_cfg.svh"
module rcpd_dimmer_asserts #(
  parameter int SLEEP_CYCLES = 20
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Settings and events.
  input wire logic [`RCPD_CHANNELS*8-1:0] channel_colour_level,
  input wire logic [`RCPD_MODULES*8-1:0] module_intensity_level,
  input wire rcpd_pkg::rcpd_ctrl_type ctrl,
  input wire logic host_cmd_seen,
  input wire logic chip_enable_pin,
  // Outputs.
  input wire logic [`RCPD_CHANNELS-1:0] sink_output,
  input wire logic power_save,
  input wire logic host_if_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Outputs lag duty by a register, so dark time is counted from outputs.
  int quiet_cnt;
  int next_quiet_cnt;
  always_comb
  begin
    next_quiet_cnt = quiet_cnt + 1;
    if (reset || sink_output != '0)
      next_quiet_cnt = 0;
  end
  always_ff @(posedge core_clk)
  begin
    quiet_cnt <= next_quiet_cnt;
  end
  off_when_idle_a: assert property (
    !ctrl.core_active ##1 !ctrl.core_active |-> sink_output == '0)
    else $error("lit while inactive");
  lit_needs_active_a: assert property (
    sink_output != '0 |-> $past(ctrl.core_active) && $past(!power_save))
    else $error("lit without active core");
  off_in_sleep_a: assert property (
    power_save ##1 power_save |-> sink_output == '0)
    else $error("lit while asleep");
  sleep_enable_a: assert property ($rose(power_save) |->
    $past(ctrl.autosleep_en) && $past(ctrl.core_active))
    else $error("sleep not allowed");
  sleep_quiet_a: assert property ($rose(power_save) |->
    quiet_cnt + 2 >= SLEEP_CYCLES) else $error("slept early");
  lit_awake_a: assert property (
    sink_output != '0 |=> !power_save [*8])
    else $error("slept while lit");
  cmd_wakes_a: assert property (host_cmd_seen |=> !power_save)
    else $error("command did not wake");
  if_pulse_a: assert property (host_if_reset |=> !host_if_reset)
    else $error("interface reset too long");
  if_time_a: assert property ($fell(chip_enable_pin) |->
    ##[1:75] host_if_reset) else $error("interface reset late");
  cover property ($rose(power_save));
  cover property ($fell(power_save));
  cover property (host_if_reset);
endmodule
bind rcpd_dimmer rcpd_dimmer_asserts #(.SLEEP_CYCLES(SLEEP_CYCLES)) chk (
  .core_clk, .reset, .channel_colour_level, .module_intensity_level, .ctrl,
  .host_cmd_seen, .chip_enable_pin, .sink_output, .power_save,
  .host_if_reset);

// ---- dv/rcpd_host_model.sv ----
`timescale 1ns/100ps
module rcpd_host_model
(
  // Clock.
  input wire logic core_clk,
  // Settings and events towards the block.
  output logic [95:0] colour,
  output logic [31:0] intensity,
  output rcpd_pkg::rcpd_ctrl_type ctrl,
  output logic cmd_seen,
  output logic enable_pin
);
  initial
  begin
    colour = 96'h0;
    intensity = 32'hFFFFFFFF;
    ctrl = 4'hB;
    cmd_seen = 1'b0;
    enable_pin = 1'b0;
  end
  task automatic power_up();
    @(posedge core_clk) #1 enable_pin = 1'b1;
    repeat (12500) @(posedge core_clk);
  endtask
  task automatic power_down();
    @(posedge core_clk) #1 enable_pin = 1'b0;
  endtask
  // Every write is an addressed command, so it also wakes the block.
  task automatic write_cfg(input logic [95:0] c, input logic [31:0] i,
    input logic [3:0] k);
    @(posedge core_clk) #1;
    colour = c;
    intensity = i;
    ctrl = k;
    cmd_seen = 1'b1;
    @(posedge core_clk) #1 cmd_seen = 1'b0;
  endtask
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [95:0] col;
  logic [31:0] inten;
  rcpd_pkg::rcpd_ctrl_type ctrl;
  logic cmd;
  logic pin;
  logic [11:0] sink;
  logic psave;
  logic ifr;
  logic [13:0] obs;
  int mismatches = 0;
  int cmp_count = 0;
  logic [15:0] hi [12];
  assign obs = {ifr, psave, sink};
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  rcpd_dimmer #(.SLEEP_CYCLES(20)) dut (.core_clk, .reset,
    .channel_colour_level(col), .module_intensity_level(inten), .ctrl,
    .host_cmd_seen(cmd), .chip_enable_pin(pin), .sink_output(sink),
    .power_save(psave), .host_if_reset(ifr));
  rcpd_host_model host (.core_clk, .colour(col), .intensity(inten),
    .ctrl, .cmd_seen(cmd), .enable_pin(pin));
  task automatic results();
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s exp %0h got %0h", what, exp, got);
    end
  endtask
  task automatic wait_for(input int idx, input logic lvl, input int lim,
    output int n);
    n = 0;
    while (obs[idx] !== lvl)
    begin
      @(posedge core_clk) #1;
      n++;
      if (n > lim)
      begin
        mismatches++;
        results();
      end
    end
  endtask
  // Duty is latched at period ends, so two periods pass before measuring.
  task automatic run(input logic [95:0] c, input logic [31:0] i,
    input logic [3:0] k, input int n);
    host.write_cfg(c, i, k);
    repeat (2048) @(posedge core_clk);
    hi = '{default: 16'h0000};
    repeat (n)
    begin
      @(posedge core_clk) #1;
      for (int j = 0; j < 12; j++)
        hi[j] += sink[j];
    end
  endtask
  initial
  begin
    int n;
    repeat (20) @(posedge core_clk);
    #1 reset = 1'b0;
    host.power_up();
    // A step is two clocks, so one 512-step period is 1024 clocks.
    run({8'hFF, 56'h0, 8'h01, {3{8'h20}}}, 32'hFFFFFFFF, 4'hB, 1024);
    check("ch0", 16'h80, hi[0]);
    check("ch3", 16'h4, hi[3]);
    check("ch11", 16'h3FC, hi[11]);
    check("awake", 16'h0, 16'(psave));
    wait_for(0, 1'b0, 4000, n);
    wait_for(0, 1'b1, 4000, n);
    wait_for(0, 1'b0, 1536, n);
    check("ch0_fall", 16'h80, 16'(n));
    wait_for(1, 1'b1, 1536, n);
    check("ch1_rise", 16'h140, 16'(n));
    wait_for(2, 1'b1, 1536, n);
    check("ch2_rise", 16'h1C0, 16'(n));
    wait_for(0, 1'b1, 1536, n);
    check("ch0_rise", 16'h80, 16'(n));
    run({8'hFF, 56'h0, 8'h01, {3{8'h20}}}, 32'hFFFFFF80, 4'hB, 1024);
    check("lin_ch2", 16'h40, hi[2]);
    check("mod1_ch3", 16'h4, hi[3]);
    // Half intensity on a log curve must stay below the linear 510 clocks.
    run({8'hFF, 80'h0, 8'hFF}, 32'hFFFFFF80, 4'hF, 1024);
    check("log_full", 16'h3FC, hi[11]);
    check("log_mid", 16'h1, 16'(hi[0] < 16'h1FE));
    run({88'h0, 8'h03}, 32'hFFFFFF28, 4'hB, 8192);
    check("dither_on", 16'hE, hi[0]);
    run({88'h0, 8'h03}, 32'hFFFFFF28, 4'h9, 8192);
    check("dither_off", 16'h0, hi[0]);
    run({96{1'b1}}, 32'hFFFFFFFF, 4'h3, 1024);
    check("inactive", 16'h0, hi[11]);
    run(96'h0, 32'hFFFFFFFF, 4'hB, 16);
    wait_for(12, 1'b1, 4000, n);
    check("dark", 16'h0, {4'h0, sink});
    host.write_cfg(96'h0, 32'hFFFFFFFF, 4'hB);
    check("woken", 16'h0, 16'(psave));
    run(96'h0, 32'hFFFFFFFF, 4'hA, 16);
    check("no_autosleep", 16'h0, 16'(psave));
    host.power_down();
    wait_for(13, 1'b1, 75, n);
    check("if_reset", 16'h1, 16'(ifr));
    results();
  end
endmodule
